/* File: core/cfg_pkg.sv */
/*
 package for the configuration pin control block: mode codes, serial memory
 read command, word and fifo sizes, initialization timing.
 assumes a 250 MHz ref_clk and mode select pins held static by the board.
*/
package cfg_pkg;
   // mode select pin patterns
   localparam logic [1:0]  MODE_ACTIVE_SERIAL  = 2'h0;
   localparam logic [1:0]  MODE_PASSIVE_SERIAL = 2'h1;
   // read command and start address shifted to the serial memory
   localparam int          CMD_BITS  = 32;
   localparam logic [31:0] CMD_WORD  = 32'h0300_0000;
   localparam logic [5:0]  CMD_LAST  = 6'(CMD_BITS - 1);
   // stream word assembly
   localparam int          WORD_BITS = 8;
   localparam logic [2:0]  BIT_LAST  = 3'(WORD_BITS - 1);
   localparam int          FIFO_DEPTH = 4;
   localparam int          CFG_BYTES_DEFAULT = 16;
   // initialization delay when no user init clock is used
   localparam int          CLK_PERIOD_PS = 4000;
   localparam int          INIT_TIME_NS  = 40;
   localparam int          INIT_CYCLES   = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [15:0] INIT_LAST     = 16'(INIT_CYCLES - 1);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_READ,
      ST_DRAIN,
      ST_INIT,
      ST_USER
   } phase_t;

   function automatic logic is_active_serial(input logic [1:0] mode);
      is_active_serial = (mode == MODE_ACTIVE_SERIAL);
   endfunction : is_active_serial
endpackage : cfg_pkg

/* File: core/cfg_fifo_if.sv */
/*
 interface carrying the configuration word stream into and out of the fifo.
 assumes the writer offers push data and the reader takes pop data on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface cfg_fifo_if #(parameter int WIDTH = 8);
   logic             push_valid;
   logic             push_ready;
   logic [WIDTH-1:0] push_data;
   logic             pop_valid;
   logic             pop_ready;
   logic [WIDTH-1:0] pop_data;

   modport user (output push_valid, push_data, pop_ready,
                 input  push_ready, pop_valid, pop_data);
   modport store (input  push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
endinterface : cfg_fifo_if
`default_nettype wire

/* File: core/cfg_fifo.sv */
/*
 small synchronous fifo for configuration words.
 assumes one clock and a synchronous active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cfg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic   ref_clk,
   input wire logic   rst_n,
   cfg_fifo_if.store  f
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr;
      logic [PW-1:0]               rd;
      logic [CW-1:0]               cnt;
   } fifo_t;

   fifo_t s;
   fifo_t next_s;
   logic  do_push;
   logic  do_pop;

   assign f.push_ready = (s.cnt != CW'(DEPTH));
   assign f.pop_valid  = (s.cnt != '0);
   assign f.pop_data   = s.mem[s.rd];

   always_comb begin
      next_s  = s;
      do_push = f.push_valid && f.push_ready;
      do_pop  = f.pop_valid && f.pop_ready;
      if (do_push) begin
         next_s.mem[s.wr] = f.push_data;
         next_s.wr = (s.wr == PW'(DEPTH - 1)) ? '0 : s.wr + PW'(1);
      end
      if (do_pop) begin
         next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : s.rd + PW'(1);
      end
      if (do_push && !do_pop) begin
         next_s.cnt = s.cnt + CW'(1);
      end else if (do_pop && !do_push) begin
         next_s.cnt = s.cnt - CW'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule : cfg_fifo
`default_nettype wire

/* File: core/config_pin_control.sv */
/*
 configuration pin control: chain enable gating, active serial read of a
 serial configuration memory, passive serial intake, init done indication,
 user init clock, global clear and output enable overrides.
 assumes all inputs synchronous to ref_clk and mode select pins held static.
*/
// Notes on behaviour
// - chip enable input low enables configuration; high keeps the device idle.
// - chain enable output goes low once configuration completes, high before.
// - active serial mode shifts read command and address out on serial output.
// - active serial mode selects memory by driving select low, deselects high.
// - passive serial mode hands serial output and select pins to user logic.
// - enabled init done pin shows user mode; otherwise it is user I/O.
// - user init clock edge releases initialization; pin is user I/O afterwards.
// - configuration bits enter on the dedicated configuration data input.
// - mode select pins are fixed by board; device picks its mode from them.
// - clear override asserted clears user registers; deasserted, design behaves normally.
// - output enable override low tri-states all pins; high, pins behave normally.
`timescale 1ns/1ps
`default_nettype none
module config_pin_control
   import cfg_pkg::*;
#(
   parameter int CFG_BYTES = cfg_pkg::CFG_BYTES_DEFAULT
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   input  wire logic                        chain_enable_in_n,
   input  wire logic [1:0]                  mode_sel,
   input  wire logic                        cfg_data_in,
   input  wire logic                        cfg_data_valid,
   output var  logic                        cfg_data_ready,
   input  wire logic                        init_clk_in,
   input  wire logic                        init_clk_use,
   input  wire logic                        init_done_enable,
   input  wire logic                        clear_override_n,
   input  wire logic                        output_enable_in,
   input  wire logic                        user_addr_pin_out,
   input  wire logic                        user_addr_pin_oe,
   input  wire logic                        user_sel_pin_out,
   input  wire logic                        user_sel_pin_oe,
   input  wire logic                        user_done_pin_out,
   input  wire logic                        user_done_pin_oe,
   input  wire logic                        cfg_word_ready,
   output var  logic [cfg_pkg::WORD_BITS-1:0] cfg_word,
   output var  logic                        cfg_word_valid,
   output var  logic                        chain_enable_out_n,
   output var  logic                        serial_cfg_addr_out,
   output var  logic                        serial_cfg_addr_oe,
   output var  logic                        cfg_memory_select_n,
   output var  logic                        cfg_memory_select_oe,
   output var  logic                        init_done_out,
   output var  logic                        init_done_oe,
   output var  logic                        user_clear_n,
   output var  logic                        user_io_enable
);
   import cfg_pkg::*;

   typedef struct packed {
      phase_t                phase;
      logic [1:0]            mode;
      logic [5:0]            bit_cnt;
      logic [CMD_BITS-1:0]   cmd;
      logic [WORD_BITS-1:0]  byte_sh;
      logic [2:0]            bitpos;
      logic                  byte_full;
      logic [15:0]           byte_cnt;
      logic [15:0]           init_cnt;
      logic                  init_prev;
      logic                  out_valid;
      logic [WORD_BITS-1:0]  out_word;
      logic                  in_ready;
      logic                  chain_out_n;
      logic                  addr_out;
      logic                  addr_oe;
      logic                  sel_n;
      logic                  sel_oe;
      logic                  done_out;
      logic                  done_oe;
      logic                  clr_n;
      logic                  io_en;
   } ctl_t;

   localparam ctl_t RESET_STATE = '{phase: ST_IDLE, mode: MODE_PASSIVE_SERIAL,
                                    cmd: CMD_WORD, chain_out_n: 1'b1, sel_n: 1'b1,
                                    clr_n: 1'b1, io_en: 1'b1, default: '0};
   localparam logic [15:0] BYTE_LAST = 16'(CFG_BYTES - 1);

   ctl_t s;
   ctl_t next_s;
   logic take_bit;
   logic as_mode;
   logic init_edge;
   logic word_pop;

   cfg_fifo_if #(.WIDTH(WORD_BITS)) fq ();

   cfg_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .f       (fq)
   );

   assign fq.push_valid = s.byte_full;
   assign fq.push_data  = s.byte_sh;
   assign fq.pop_ready  = !s.out_valid || cfg_word_ready;

   always_comb begin
      next_s    = s;
      as_mode   = is_active_serial(s.mode);
      init_edge = !s.init_prev && init_clk_in;
      word_pop  = fq.pop_valid && fq.pop_ready;
      take_bit  = (s.phase == ST_READ) && (as_mode ? (!s.byte_full || fq.push_ready)
                                                   : (cfg_data_valid && s.in_ready));
      next_s.init_prev = init_clk_in;
      if (s.byte_full && fq.push_ready) begin
         next_s.byte_full = 1'b0;
      end
      // output stage drains the fifo
      if (word_pop) begin
         next_s.out_valid = 1'b1;
         next_s.out_word  = fq.pop_data;
      end else if (cfg_word_ready) begin
         next_s.out_valid = 1'b0;
      end
      case (s.phase)
         ST_IDLE: begin
            if (!chain_enable_in_n) begin
               next_s.mode     = mode_sel;
               next_s.cmd      = CMD_WORD;
               next_s.bit_cnt  = '0;
               next_s.bitpos   = '0;
               next_s.byte_cnt = '0;
               next_s.phase    = is_active_serial(mode_sel) ? ST_CMD : ST_READ;
            end
         end
         ST_CMD: begin
            next_s.cmd     = {s.cmd[CMD_BITS-2:0], 1'b0};
            next_s.bit_cnt = s.bit_cnt + 6'(1);
            if (s.bit_cnt == CMD_LAST) begin
               next_s.phase = ST_READ;
            end
         end
         ST_READ: begin
            if (take_bit) begin
               next_s.byte_sh = {s.byte_sh[WORD_BITS-2:0], cfg_data_in};
               next_s.bitpos  = s.bitpos + 3'(1);
               if (s.bitpos == BIT_LAST) begin
                  next_s.byte_full = 1'b1;
                  next_s.byte_cnt  = s.byte_cnt + 16'(1);
                  if (s.byte_cnt == BYTE_LAST) begin
                     next_s.phase = ST_DRAIN;
                  end
               end
            end
         end
         ST_DRAIN: begin
            if (!s.byte_full && !fq.pop_valid && !s.out_valid) begin
               next_s.phase    = ST_INIT;
               next_s.init_cnt = '0;
            end
         end
         ST_INIT: begin
            next_s.init_cnt = s.init_cnt + 16'(1);
            if (init_clk_use ? init_edge : (s.init_cnt == INIT_LAST)) begin
               next_s.phase = ST_USER;
            end
         end
         ST_USER: begin
            next_s.phase = ST_USER;
         end
         default: begin
            next_s.phase = ST_IDLE;
         end
      endcase
      // disabled chip enable abandons an unfinished load
      if (chain_enable_in_n && (s.phase inside {ST_CMD, ST_READ})) begin
         next_s.phase     = ST_IDLE;
         next_s.byte_full = 1'b0;
      end
      next_s.chain_out_n = !(next_s.phase inside {ST_INIT, ST_USER});
      next_s.in_ready    = (next_s.phase == ST_READ) && !is_active_serial(next_s.mode)
                           && !next_s.byte_full;
      // dual purpose pins
      if (is_active_serial(next_s.mode) && next_s.phase != ST_USER) begin
         next_s.addr_out = (next_s.phase == ST_CMD) && next_s.cmd[CMD_BITS-1];
         next_s.addr_oe  = 1'b1;
         next_s.sel_n    = !(next_s.phase inside {ST_CMD, ST_READ});
         next_s.sel_oe   = 1'b1;
      end else if (next_s.phase == ST_USER || !is_active_serial(next_s.mode)) begin
         next_s.addr_out = user_addr_pin_out;
         next_s.addr_oe  = user_addr_pin_oe;
         next_s.sel_n    = user_sel_pin_out;
         next_s.sel_oe   = user_sel_pin_oe;
      end
      if (init_done_enable) begin
         next_s.done_out = (next_s.phase == ST_USER);
         next_s.done_oe  = 1'b1;
      end else begin
         next_s.done_out = (next_s.phase == ST_USER) && user_done_pin_out;
         next_s.done_oe  = (next_s.phase == ST_USER) && user_done_pin_oe;
      end
      next_s.clr_n = clear_override_n;
      next_s.io_en = output_enable_in;
      if (!output_enable_in) begin
         next_s.addr_oe = 1'b0;
         next_s.sel_oe  = 1'b0;
         next_s.done_oe = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   assign cfg_data_ready       = s.in_ready;
   assign cfg_word             = s.out_word;
   assign cfg_word_valid       = s.out_valid;
   assign chain_enable_out_n   = s.chain_out_n;
   assign serial_cfg_addr_out  = s.addr_out;
   assign serial_cfg_addr_oe   = s.addr_oe;
   assign cfg_memory_select_n  = s.sel_n;
   assign cfg_memory_select_oe = s.sel_oe;
   assign init_done_out        = s.done_out;
   assign init_done_oe         = s.done_oe;
   assign user_clear_n         = s.clr_n;
   assign user_io_enable       = s.io_en;

   property p_idle_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      (s.phase == ST_IDLE && chain_enable_in_n) |=> (s.phase == ST_IDLE);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("left idle while disabled");

   property p_chain_high;
      @(posedge ref_clk) disable iff (!rst_n)
      (s.phase inside {ST_IDLE, ST_CMD, ST_READ, ST_DRAIN}) |-> chain_enable_out_n;
   endproperty
   a_chain_high: assert property (p_chain_high) else $error("chain enable low early");

   property p_cmd_len;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(s.phase == ST_CMD) ##1 (s.phase == ST_CMD)[*8] ##1 (s.phase == ST_CMD)[*8]
         ##1 (s.phase == ST_CMD)[*8] ##1 (s.phase == ST_CMD)[*7] |=> (s.phase != ST_CMD);
   endproperty
   a_cmd_len: assert property (p_cmd_len) else $error("command length wrong");

   property p_cmd_first_bit;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(s.phase == ST_CMD) |-> (serial_cfg_addr_out == CMD_WORD[CMD_BITS-1]);
   endproperty
   a_cmd_first_bit: assert property (p_cmd_first_bit) else $error("bad first cmd bit");

   property p_select_low;
      @(posedge ref_clk) disable iff (!rst_n)
      (is_active_serial(s.mode) && (s.phase inside {ST_CMD, ST_READ})) |-> !cfg_memory_select_n;
   endproperty
   a_select_low: assert property (p_select_low) else $error("memory not selected");

   property p_passive_pins;
      @(posedge ref_clk) disable iff (!rst_n)
      (s.phase != ST_IDLE && !is_active_serial(s.mode) && output_enable_in)
         |=> (cfg_memory_select_n == $past(user_sel_pin_out))
             && (serial_cfg_addr_oe == $past(user_addr_pin_oe));
   endproperty
   a_passive_pins: assert property (p_passive_pins) else $error("pins not released");

   property p_done_shows_user;
      @(posedge ref_clk) disable iff (!rst_n)
      (s.phase == ST_USER && init_done_enable) |=> init_done_out;
   endproperty
   a_done_shows_user: assert property (p_done_shows_user) else $error("init done low");

   property p_init_wait;
      @(posedge ref_clk) disable iff (!rst_n)
      (s.phase == ST_INIT && init_clk_use && !(!s.init_prev && init_clk_in))
         |=> (s.phase == ST_INIT);
   endproperty
   a_init_wait: assert property (p_init_wait) else $error("init left without edge");

   property p_mode_capture;
      @(posedge ref_clk) disable iff (!rst_n)
      (s.phase == ST_IDLE && !chain_enable_in_n) |=> (s.mode == $past(mode_sel));
   endproperty
   a_mode_capture: assert property (p_mode_capture) else $error("mode not taken");

   property p_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      !clear_override_n ##1 !clear_override_n |-> !user_clear_n;
   endproperty
   a_clear: assert property (p_clear) else $error("clear not applied");

   property p_tristate;
      @(posedge ref_clk) disable iff (!rst_n)
      !output_enable_in |=> !serial_cfg_addr_oe && !cfg_memory_select_oe && !init_done_oe;
   endproperty
   a_tristate: assert property (p_tristate) else $error("pin driven under override");

   c_active_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
      is_active_serial(s.mode) && $rose(s.phase == ST_USER));
   c_passive_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
      !is_active_serial(s.mode) && $rose(s.phase == ST_USER));
   c_fifo_full: cover property (@(posedge ref_clk) disable iff (!rst_n)
      s.byte_full && !fq.push_ready);
endmodule : config_pin_control
`default_nettype wire

/* File: sim/serial_cfg_memory.sv */
/*
 behavioural serial configuration memory: takes the 32 bit read command while
 selected, then returns NUM_BYTES bytes msb first, one bit per ref_clk cycle.
 assumes the device samples the first data bit one cycle after the last command bit.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_cfg_memory #(
   parameter int NUM_BYTES = 8
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        select_n,
   input  wire logic        select_oe,
   input  wire logic        addr_in,
   input  wire logic        addr_oe,
   output var  logic        data_out,
   output var  logic [31:0] cmd_seen
);
   int         cmd_count = 0;
   int         bit_index = 0;
   logic [7:0] cur;
   initial data_out = 1'b0;
   initial cmd_seen = 32'h0000_0000;
   always @(posedge ref_clk) begin
      cur = 8'(8'h3C + bit_index / 8 * 8'h51);
      if (!rst_n || select_n || !select_oe || !addr_oe) begin
         // deselected: restart and keep the data line moving
         cmd_count <= 0;
         bit_index <= 0;
         data_out  <= #1 ~data_out;
         if (!rst_n) begin
            cmd_seen <= 32'h0000_0000;
         end
      end else if (cmd_count < 32) begin
         cmd_seen  <= {cmd_seen[30:0], addr_in};
         cmd_count <= cmd_count + 1;
         if (cmd_count == 31) begin
            data_out  <= #1 cur[7];
            bit_index <= 1;
         end else begin
            data_out  <= #1 ~data_out;
         end
      end else begin
         data_out  <= #1 (bit_index < NUM_BYTES * 8) ? cur[7 - bit_index % 8] : ~data_out;
         bit_index <= bit_index + 1;
      end
   end
endmodule : serial_cfg_memory
`default_nettype wire

/* File: sim/config_pin_control_bench.sv */
/*
 bench for config_pin_control: passive load with stalled consumer and init clock,
 pin table, mode loop with abort, active serial load from the memory model.
 assumes the design modules and cfg_pkg are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module config_pin_control_bench;
   import cfg_pkg::*;
   localparam int NB = 8;
   typedef struct packed { logic [8:0] stim; logic [7:0] expect_v; } row_t;
   localparam row_t ROWS [6] = '{'{9'h1B7, 8'hDF}, '{9'h19C, 8'h73}, '{9'h0BF, 8'hAA},
                                 '{9'h100, 8'h01}, '{9'h1C0, 8'h0F}, '{9'h040, 8'h08}};
   logic ref_clk = 1'b0, rst_n = 1'b0, chain_enable_in_n = 1'b1, use_mem = 1'b0;
   logic [1:0] mode_sel = 2'h0;
   logic ps_bit = 1'b0, cfg_data_valid = 1'b0, init_clk_in = 1'b0, init_clk_use = 1'b0;
   logic init_done_enable = 1'b0, clear_override_n = 1'b1, output_enable_in = 1'b1;
   logic user_addr_pin_out = 1'b0, user_addr_pin_oe = 1'b0, user_sel_pin_out = 1'b1;
   logic user_sel_pin_oe = 1'b0, user_done_pin_out = 1'b0, user_done_pin_oe = 1'b0;
   logic cfg_word_ready = 1'b0, cfg_data_ready, cfg_word_valid, chain_enable_out_n;
   logic [7:0] cfg_word;
   logic serial_cfg_addr_out, serial_cfg_addr_oe, cfg_memory_select_n, cfg_memory_select_oe;
   logic init_done_out, init_done_oe, user_clear_n, user_io_enable, mem_data, cfg_in;
   logic [31:0] cmd_seen;
   logic [7:0] got [$];
   int bad_count = 0;
   int num_checks = 0;
   int n;
   assign cfg_in = use_mem ? mem_data : ps_bit;
   always #2 ref_clk = ~ref_clk;

   config_pin_control #(.CFG_BYTES(NB)) config_pin_control_inst (
      .ref_clk, .rst_n, .chain_enable_in_n, .mode_sel, .cfg_data_in(cfg_in), .cfg_data_valid,
      .cfg_data_ready, .init_clk_in, .init_clk_use, .init_done_enable, .clear_override_n,
      .output_enable_in, .user_addr_pin_out, .user_addr_pin_oe, .user_sel_pin_out,
      .user_sel_pin_oe, .user_done_pin_out, .user_done_pin_oe, .cfg_word_ready, .cfg_word,
      .cfg_word_valid, .chain_enable_out_n, .serial_cfg_addr_out, .serial_cfg_addr_oe,
      .cfg_memory_select_n, .cfg_memory_select_oe, .init_done_out, .init_done_oe,
      .user_clear_n, .user_io_enable);
   serial_cfg_memory #(.NUM_BYTES(NB)) serial_cfg_memory_inst (
      .ref_clk, .rst_n, .select_n(cfg_memory_select_n), .select_oe(cfg_memory_select_oe),
      .addr_in(serial_cfg_addr_out), .addr_oe(serial_cfg_addr_oe), .data_out(mem_data),
      .cmd_seen);

   always @(posedge ref_clk) begin
      if (rst_n && cfg_word_valid === 1'b1 && cfg_word_ready === 1'b1) begin
         got.push_back(cfg_word);
      end
   end

   function automatic logic [7:0] exp_byte(input int k);
      exp_byte = 8'(8'h3C + k * 8'h51);
   endfunction : exp_byte

   task automatic print_verdict();
      if (bad_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
      num_checks++;
      if (got_v !== exp_v) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask : check

   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step

   task automatic wait_level(ref logic s, input logic v, input int limit);
      for (int i = 0; i < limit; i++) begin
         if (s === v) begin
            return;
         end
         step();
      end
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, s, v);
      print_verdict();
   endtask : wait_level

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (4) step();
      rst_n = 1'b1;
   endtask : do_reset

   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         ps_bit = b[i];
         cfg_data_valid = 1'b1;
         wait_level(cfg_data_ready, 1'b1, 400);
         step();
      end
   endtask : send_byte

   task automatic check_bytes();
      check(got.size(), NB);
      foreach (got[k]) begin
         check(got[k], exp_byte(k));
      end
   endtask : check_bytes

   initial begin
      repeat (4) step();
      check({chain_enable_out_n, cfg_memory_select_n, user_clear_n, user_io_enable}, 4'hF);
      check({cfg_data_ready, cfg_word_valid, serial_cfg_addr_oe, init_done_out}, 4'h0);
      rst_n = 1'b1;
      // passive load, consumer stalled until the buffer refuses
      mode_sel = 2'h1;
      init_clk_use = 1'b1;
      init_done_enable = 1'b1;
      chain_enable_in_n = 1'b0;
      fork
         begin
            for (int k = 0; k < NB; k++) send_byte(exp_byte(k));
         end
         begin
            repeat (150) step();
            check({cfg_data_ready, cfg_word_valid, chain_enable_out_n}, 3'h3);
            cfg_word_ready = 1'b1;
         end
      join
      cfg_data_valid = 1'b0;
      wait_level(chain_enable_out_n, 1'b0, 200);
      check_bytes();
      repeat (20) step();
      check(init_done_out, 1'b0);
      init_clk_in = 1'b1;
      wait_level(init_done_out, 1'b1, 4);
      check(init_done_oe, 1'b1);
      // user mode pin table
      foreach (ROWS[i]) begin
         {output_enable_in, clear_override_n, init_done_enable, user_addr_pin_out,
          user_addr_pin_oe, user_sel_pin_out, user_sel_pin_oe, user_done_pin_out,
          user_done_pin_oe} = ROWS[i].stim;
         repeat (2) step();
         check({serial_cfg_addr_out, serial_cfg_addr_oe, cfg_memory_select_n,
                cfg_memory_select_oe, init_done_out, init_done_oe, user_clear_n,
                user_io_enable}, ROWS[i].expect_v);
      end
      {output_enable_in, clear_override_n, init_done_enable, user_addr_pin_out,
       user_addr_pin_oe, user_sel_pin_out, user_sel_pin_oe, user_done_pin_out,
       user_done_pin_oe} = 9'h188;
      // every mode code, then abort in mid load
      for (int m = 0; m < 4; m++) begin
         chain_enable_in_n = 1'b1;
         do_reset();
         mode_sel = 2'(m);
         use_mem = (m == 0);
         repeat (3) step();
         check(cfg_memory_select_n, 1'b1);
         chain_enable_in_n = 1'b0;
         repeat (3) step();
         check({cfg_memory_select_n, serial_cfg_addr_oe, cfg_data_ready},
               (m == 0) ? 3'h2 : 3'h5);
         chain_enable_in_n = 1'b1;
         repeat (2) step();
         check({cfg_memory_select_n, cfg_data_ready}, 2'h2);
      end
      // active serial load with fixed init delay
      do_reset();
      mode_sel = 2'h0;
      init_clk_use = 1'b0;
      init_done_enable = 1'b1;
      use_mem = 1'b1;
      got.delete();
      chain_enable_in_n = 1'b0;
      wait_level(cfg_word_valid, 1'b1, 200);
      check({chain_enable_out_n, cfg_memory_select_n}, 2'h2);
      wait_level(chain_enable_out_n, 1'b0, 400);
      check_bytes();
      check(cmd_seen, 32'h0300_0000);
      check(cfg_memory_select_n, 1'b1);
      n = 0;
      while (init_done_out !== 1'b1 && n < 50) begin
         step();
         n++;
      end
      check(n, 10);
      print_verdict();
   end
endmodule : config_pin_control_bench
`default_nettype wire
